// ### include/lrx_defs.svh
// register map, field positions and filter bounds of the link control bank
`ifndef LRX_DEFS_SVH
`define LRX_DEFS_SVH
`define LRX_CTRL_OFF 6'h02
`define LRX_CTRL_RESET 32'h0000_0000
`define LRX_RX_EN 6
`define LRX_PH_BUSY 7
`define LRX_PH_ON 8
`define LRX_PH_RO 9
`define LRX_TX_RST 10
`define LRX_RX_RST 11
`define LRX_BLK_LO 12
`define LRX_BLK_HI 15
`define LRX_RC_LO 16
`define LRX_RC_HI 17
`define LRX_BCAST_NODE 6'h3F
`define LRX_LOW_SPACE_TOP 16'h0000
`define LRX_BUSDEP_LOW_FIRST 48'hFFFF_F000_0200
`define LRX_BUSDEP_LOW_LAST 48'hFFFF_F000_027F
`define LRX_BUSDEP_HIGH_FIRST 48'hFFFF_F000_0380
`define LRX_BUSDEP_HIGH_LAST 48'hFFFF_F000_03FF
`endif

// ### include/lrx_pkg.sv
// shared types of the link control bank
package lrx_pkg;
	typedef enum logic [1:0]
	{
		LRX_RETRY_0 = 2'h0,
		LRX_RETRY_X = 2'h1,
		LRX_RETRY_A = 2'h2,
		LRX_RETRY_B = 2'h3
	} lrx_retry_t;
endpackage

// ### rtl/lrx_link_control.sv
// link control register bank: receive filter, soft resets and retry code capture
`include "lrx_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module lrx_link_control
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_valid_i,
	input wire logic [5:0] rx_dest_node_i,
	input wire logic [47:0] rx_offset_i,
	input wire logic rx_is_request_i,
	input wire logic rx_is_write_i,
	output logic rx_accept_o,
	output logic rx_busy_ack_o,
	output logic rx_reject_o,
	input wire logic tx_ack_valid_i,
	input wire logic [1:0] tx_ack_retry_i,
	input wire logic tx_resend_i,
	input wire logic [1:0] tx_pkt_retry_i,
	output logic tx_resend_o,
	output logic [1:0] tx_resend_code_o,
	output logic tx_soft_reset_o,
	output logic rx_soft_reset_o
);

	// ********************************
	// register storage
	// ********************************
	logic receiver_enable;
	logic phys_access_busy;
	logic phys_access_active;
	logic phys_access_read_only;
	logic [3:0] broadcast_csr_block;
	lrx_pkg::lrx_retry_t last_retry_code;
	logic [31:0] ctrl_view;
	logic bus_req;
	logic ctrl_hit;
	logic ctrl_wr;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ctrl_hit = wb_adr_i[7:2] == `LRX_CTRL_OFF;
	assign ctrl_wr = bus_req && wb_we_i && ctrl_hit;

	always_comb
	begin
		ctrl_view = `LRX_CTRL_RESET;
		ctrl_view[`LRX_RX_EN] = receiver_enable;
		ctrl_view[`LRX_PH_BUSY] = phys_access_busy;
		ctrl_view[`LRX_PH_ON] = phys_access_active;
		ctrl_view[`LRX_PH_RO] = phys_access_read_only;
		ctrl_view[`LRX_TX_RST] = tx_soft_reset_o;
		ctrl_view[`LRX_RX_RST] = rx_soft_reset_o;
		ctrl_view[`LRX_BLK_HI:`LRX_BLK_LO] = broadcast_csr_block;
		ctrl_view[`LRX_RC_HI:`LRX_RC_LO] = last_retry_code;
	end

	// ********************************
	// wishbone slave, one wait-free ack
	// ********************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `LRX_CTRL_RESET;
		end
		else
		begin
			wb_ack_o <= bus_req;
			// unmapped addresses answer with zero
			wb_dat_o <= (bus_req && !wb_we_i && ctrl_hit) ? ctrl_view : `LRX_CTRL_RESET;
		end
	end

	// only bytes 0 and 1 hold writable fields
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			receiver_enable <= 1'b0;
			phys_access_busy <= 1'b0;
			phys_access_active <= 1'b0;
			phys_access_read_only <= 1'b0;
			broadcast_csr_block <= 4'h0;
		end
		else
		begin
			if (ctrl_wr && wb_sel_i[0])
			begin
				receiver_enable <= wb_dat_i[`LRX_RX_EN];
				phys_access_busy <= wb_dat_i[`LRX_PH_BUSY];
			end
			if (ctrl_wr && wb_sel_i[1])
			begin
				phys_access_active <= wb_dat_i[`LRX_PH_ON];
				phys_access_read_only <= wb_dat_i[`LRX_PH_RO];
				broadcast_csr_block <= wb_dat_i[`LRX_BLK_HI:`LRX_BLK_LO];
			end
		end
	end

	// ********************************
	// self-clearing soft resets
	// ********************************
	// a set bit lives one cycle and doubles as the reset pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_soft_reset_o <= 1'b0;
			rx_soft_reset_o <= 1'b0;
		end
		else
		begin
			tx_soft_reset_o <= ctrl_wr && wb_sel_i[1] && wb_dat_i[`LRX_TX_RST];
			rx_soft_reset_o <= ctrl_wr && wb_sel_i[1] && wb_dat_i[`LRX_RX_RST];
		end
	end

	// ********************************
	// receive filter
	// ********************************
	logic is_bcast;
	logic low_space;
	logic blk_low;
	logic blk_high;
	logic ph_busy;
	logic ph_refuse;

	assign is_bcast = rx_dest_node_i == `LRX_BCAST_NODE;
	assign low_space = rx_offset_i[47:32] == `LRX_LOW_SPACE_TOP;
	assign blk_low = broadcast_csr_block[0] && rx_offset_i >= `LRX_BUSDEP_LOW_FIRST
		&& rx_offset_i <= `LRX_BUSDEP_LOW_LAST;
	assign blk_high = broadcast_csr_block[3] && rx_offset_i >= `LRX_BUSDEP_HIGH_FIRST
		&& rx_offset_i <= `LRX_BUSDEP_HIGH_LAST;
	// physical checks only apply to low-space requests with the path on
	assign ph_busy = phys_access_active && rx_is_request_i && low_space
		&& (!phys_access_read_only || !rx_is_write_i) && phys_access_busy;
	assign ph_refuse = phys_access_active && rx_is_request_i && low_space
		&& phys_access_read_only && rx_is_write_i;

	// a receiver reset aborts any decision in flight
	always_ff @(posedge clk_i)
	begin
		if (rst_i || rx_soft_reset_o)
		begin
			rx_accept_o <= 1'b0;
			rx_busy_ack_o <= 1'b0;
			rx_reject_o <= 1'b0;
		end
		else if (!rx_valid_i || !receiver_enable)
		begin
			rx_accept_o <= 1'b0;
			rx_busy_ack_o <= 1'b0;
			rx_reject_o <= 1'b0;
		end
		else if (is_bcast && (blk_low || blk_high))
		begin
			rx_accept_o <= 1'b0;
			rx_busy_ack_o <= 1'b0;
			rx_reject_o <= 1'b1;
		end
		else if (ph_busy)
		begin
			rx_accept_o <= 1'b0;
			rx_busy_ack_o <= 1'b1;
			rx_reject_o <= 1'b0;
		end
		else if (ph_refuse)
		begin
			rx_accept_o <= 1'b0;
			rx_busy_ack_o <= 1'b0;
			rx_reject_o <= 1'b1;
		end
		else
		begin
			rx_accept_o <= 1'b1;
			rx_busy_ack_o <= 1'b0;
			rx_reject_o <= 1'b0;
		end
	end

	// ********************************
	// retry code capture and resend
	// ********************************
	// read-only to software: no bus path writes it
	always_ff @(posedge clk_i)
	begin
		if (rst_i || tx_soft_reset_o)
			last_retry_code <= lrx_pkg::LRX_RETRY_0;
		else if (tx_ack_valid_i)
			last_retry_code <= lrx_pkg::lrx_retry_t'(tx_ack_retry_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || tx_soft_reset_o)
		begin
			tx_resend_o <= 1'b0;
			tx_resend_code_o <= 2'h0;
		end
		else
		begin
			tx_resend_o <= tx_resend_i;
			// software leaves the packet field at new, so OR merges cleanly
			tx_resend_code_o <= tx_resend_i ? (tx_pkt_retry_i | last_retry_code) : 2'h0;
		end
	end

	// ********************************
	// checks
	// ********************************
	rx_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!receiver_enable && !$past(receiver_enable) |-> !rx_accept_o && !rx_busy_ack_o)
		else $error("packet taken while receiver disabled");
	busy_ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_busy_ack_o |-> $past(phys_access_active && phys_access_busy && rx_valid_i && receiver_enable))
		else $error("busy ack without physical busy");
	phys_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && !phys_access_active && !is_bcast && !rx_soft_reset_o
		|=> rx_accept_o)
		else $error("physical bits applied while path off");
	ro_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && !is_bcast && ph_refuse && !rx_soft_reset_o
		|=> rx_reject_o && !rx_accept_o)
		else $error("read-only low write accepted");
	tx_reset_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_soft_reset_o |=> !tx_soft_reset_o && last_retry_code == lrx_pkg::LRX_RETRY_0 && !tx_resend_o)
		else $error("transmitter reset did not clear");
	rx_reset_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_soft_reset_o |=> !rx_soft_reset_o && !rx_accept_o)
		else $error("receiver reset did not clear");
	bcast_low_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && is_bcast && blk_low && !rx_soft_reset_o |=> rx_reject_o)
		else $error("blocked low broadcast received");
	bcast_high_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && is_bcast && blk_high && !rx_soft_reset_o |=> rx_reject_o)
		else $error("blocked high broadcast received");
	retry_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_ack_valid_i && !tx_soft_reset_o |=> last_retry_code == $past(tx_ack_retry_i))
		else $error("retry code not captured");
	resend_merge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_resend_i && !tx_soft_reset_o |=> tx_resend_o
		&& tx_resend_code_o == ($past(tx_pkt_retry_i) | $past(last_retry_code)))
		else $error("resend code not merged");
	bcast_accept_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && is_bcast && !blk_low && !blk_high && !ph_busy && !ph_refuse
		&& !rx_soft_reset_o |=> rx_accept_o)
		else $error("broadcast not accepted");
	retry_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!tx_ack_valid_i && !tx_soft_reset_o |=> $stable(last_retry_code))
		else $error("retry code changed without an acknowledge");
	wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// ********************************
	// bus, receive and transmit checks
	// ********************************
	// read data must be zero outside an ack so a late sampler sees nothing stale
	wb_dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == `LRX_CTRL_RESET)
		else $error("read data outside ack");
	wb_ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	wb_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && $past(!ctrl_hit) |-> wb_dat_o == `LRX_CTRL_RESET)
		else $error("unmapped read not zero");
	enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_wr && wb_sel_i[0] |=> receiver_enable == $past(wb_dat_i[`LRX_RX_EN]))
		else $error("receiver enable not stored");
	phys_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_wr && wb_sel_i[1] |=> phys_access_active == $past(wb_dat_i[`LRX_PH_ON])
		&& phys_access_read_only == $past(wb_dat_i[`LRX_PH_RO]))
		else $error("physical access bits not stored");
	block_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_wr && wb_sel_i[1] |=> broadcast_csr_block == $past(wb_dat_i[`LRX_BLK_HI:`LRX_BLK_LO]))
		else $error("broadcast block field not stored");
	rx_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0({rx_accept_o, rx_busy_ack_o, rx_reject_o}))
		else $error("more than one receive decision");
	rx_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && !rx_soft_reset_o |=> $onehot({rx_accept_o, rx_busy_ack_o, rx_reject_o}))
		else $error("packet got no decision");
	rx_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rx_valid_i |=> !rx_accept_o && !rx_busy_ack_o && !rx_reject_o)
		else $error("decision without a packet");
	busy_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && ph_busy && !(is_bcast && (blk_low || blk_high))
		&& !rx_soft_reset_o |=> rx_busy_ack_o)
		else $error("busy ack missing");
	busy_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_busy_ack_o |-> $past(phys_access_active && low_space && rx_is_request_i))
		else $error("busy ack outside low request space");
	ro_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && receiver_enable && !rx_is_write_i && !ph_busy && !(is_bcast && (blk_low || blk_high))
		&& !rx_soft_reset_o |=> rx_accept_o)
		else $error("read refused");
	reject_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_reject_o |-> $past((is_bcast && (blk_low || blk_high)) || ph_refuse))
		else $error("packet dropped without cause");
	rx_reset_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_soft_reset_o |=> !rx_busy_ack_o && !rx_reject_o)
		else $error("receiver reset left a decision");
	rx_reset_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_soft_reset_o |=> !ctrl_view[`LRX_RX_RST])
		else $error("receiver reset bit still set");
	tx_reset_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_soft_reset_o |-> $past(ctrl_wr && wb_dat_i[`LRX_TX_RST]))
		else $error("transmitter reset without a write");
	resend_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!tx_resend_i |=> !tx_resend_o && tx_resend_code_o == lrx_pkg::LRX_RETRY_0)
		else $error("resend output without request");
	// software writes must never reach the captured code
	soft_write_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_wr && !tx_ack_valid_i && !tx_soft_reset_o |=> $stable(last_retry_code))
		else $error("retry code written by software");

	busy_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) rx_busy_ack_o);
	bcast_drop_c: cover property (@(posedge clk_i) disable iff (rst_i) rx_valid_i && is_bcast && blk_high ##1 rx_reject_o);
	resend_c: cover property (@(posedge clk_i) disable iff (rst_i) tx_ack_valid_i ##[1:4] tx_resend_i);
	rx_reset_c: cover property (@(posedge clk_i) disable iff (rst_i) rx_soft_reset_o);
	ro_read_busy_c: cover property (@(posedge clk_i) disable iff (rst_i)
		rx_valid_i && !rx_is_write_i && phys_access_read_only ##1 rx_busy_ack_o);

endmodule
`default_nettype wire

// ### verif/lrx_node_model.sv
// far-side node model: received packet headers, acks and resend requests
`timescale 1ns/1ns
`default_nettype none
module lrx_node_model
(
	input wire logic clk_i,
	output logic rx_valid_o,
	output logic [5:0] rx_dest_node_o,
	output logic [47:0] rx_offset_o,
	output logic rx_is_request_o,
	output logic rx_is_write_o,
	output logic tx_ack_valid_o,
	output logic [1:0] tx_ack_retry_o,
	output logic tx_resend_o,
	output logic [1:0] tx_pkt_retry_o
);
	// ****************
	// pulse drivers
	// ****************
	// fields start at zero and after a pulse show its inverse so stale headers never look valid
	initial
	begin
		{rx_valid_o, tx_ack_valid_o, tx_resend_o} = 3'h0;
		{rx_dest_node_o, rx_offset_o, rx_is_request_o, rx_is_write_o} = 56'h0;
		{tx_ack_retry_o, tx_pkt_retry_o} = 4'h0;
	end
	task automatic send_pkt(input logic [5:0] node, input logic [47:0] off, input logic req, input logic wr);
		@(posedge clk_i);
		rx_valid_o <= 1'h1;
		{rx_dest_node_o, rx_offset_o, rx_is_request_o, rx_is_write_o} <= {node, off, req, wr};
		@(posedge clk_i);
		rx_valid_o <= 1'h0;
		{rx_dest_node_o, rx_offset_o, rx_is_request_o, rx_is_write_o} <= ~{node, off, req, wr};
	endtask
	task automatic send_ack(input logic [1:0] code);
		@(posedge clk_i);
		tx_ack_valid_o <= 1'h1;
		tx_ack_retry_o <= code;
		@(posedge clk_i);
		tx_ack_valid_o <= 1'h0;
		tx_ack_retry_o <= ~code;
	endtask
	task automatic resend(input logic [1:0] field);
		@(posedge clk_i);
		tx_resend_o <= 1'h1;
		tx_pkt_retry_o <= field;
		@(posedge clk_i);
		tx_resend_o <= 1'h0;
		tx_pkt_retry_o <= ~field;
	endtask
endmodule
`default_nettype wire

// ### verif/lrx_link_control_tb.sv
// testbench of the link control bank
`timescale 1ns/1ns
`default_nettype none
module lrx_link_control_tb;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic rx_valid_i, rx_is_request_i, rx_is_write_i, rx_accept_o, rx_busy_ack_o, rx_reject_o;
	logic [5:0] rx_dest_node_i;
	logic [47:0] rx_offset_i;
	logic tx_ack_valid_i, tx_resend_i, tx_resend_o, tx_soft_reset_o, rx_soft_reset_o;
	logic [1:0] tx_ack_retry_i, tx_pkt_retry_i, tx_resend_code_o;
	int err_count = 0, n_tests = 0, cycles = 0, n_txr = 0, n_rxr = 0, c0;
	lrx_link_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_dest_node_i(rx_dest_node_i),
		.rx_offset_i(rx_offset_i), .rx_is_request_i(rx_is_request_i), .rx_is_write_i(rx_is_write_i),
		.rx_accept_o(rx_accept_o), .rx_busy_ack_o(rx_busy_ack_o), .rx_reject_o(rx_reject_o),
		.tx_ack_valid_i(tx_ack_valid_i), .tx_ack_retry_i(tx_ack_retry_i), .tx_resend_i(tx_resend_i),
		.tx_pkt_retry_i(tx_pkt_retry_i), .tx_resend_o(tx_resend_o), .tx_resend_code_o(tx_resend_code_o),
		.tx_soft_reset_o(tx_soft_reset_o), .rx_soft_reset_o(rx_soft_reset_o));
	lrx_node_model u_node (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_dest_node_o(rx_dest_node_i),
		.rx_offset_o(rx_offset_i), .rx_is_request_o(rx_is_request_i), .rx_is_write_o(rx_is_write_i),
		.tx_ack_valid_o(tx_ack_valid_i), .tx_ack_retry_o(tx_ack_retry_i), .tx_resend_o(tx_resend_i),
		.tx_pkt_retry_o(tx_pkt_retry_i));
	// ****************
	// tasks
	// ****************
	task automatic test_done();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask
	// waits on ack only; the cycle timeout bounds it
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	task automatic rx_case(input logic [31:0] ctrl, input logic [5:0] node, input logic [47:0] off,
		input logic req, input logic wr, input logic [2:0] exp);
		bus(1'h1, 8'h08, ctrl);
		u_node.send_pkt(node, off, req, wr);
		@(negedge clk_i);
		chk({29'h0, rx_accept_o, rx_busy_ack_o, rx_reject_o}, {29'h0, exp});
	endtask
	// ****************
	// tests
	// ****************
	initial
	begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		n_txr += (tx_soft_reset_o === 1'h1);
		n_rxr += (rx_soft_reset_o === 1'h1);
		if (cycles == 3000)
		begin
			err_count++;
			test_done();
		end
	end
	initial
	begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 40'h0};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(1'h1, 8'h08, 32'hFFFF_F3C0);
		bus(1'h1, 8'h10, 32'hFFFF_FFFF);
		bus(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0000_F3C0);
		rx_case(32'h0000_0000, 6'h01, 48'h0, 1'h1, 1'h1, 3'h0);
		rx_case(32'h0000_0040, 6'h01, 48'h0, 1'h1, 1'h1, 3'h4);
		rx_case(32'h0000_01C0, 6'h01, 48'h0, 1'h1, 1'h0, 3'h2);
		rx_case(32'h0000_03C0, 6'h01, 48'h0, 1'h1, 1'h0, 3'h2);
		rx_case(32'h0000_03C0, 6'h01, 48'h0, 1'h1, 1'h1, 3'h1);
		rx_case(32'h0000_0340, 6'h01, 48'h0, 1'h1, 1'h0, 3'h4);
		rx_case(32'h0000_02C0, 6'h01, 48'h0, 1'h1, 1'h1, 3'h4);
		rx_case(32'h0000_01C0, 6'h01, 48'h1_0000_0000, 1'h1, 1'h0, 3'h4);
		rx_case(32'h0000_01C0, 6'h01, 48'h0, 1'h0, 1'h0, 3'h4);
		rx_case(32'h0000_1040, 6'h3F, 48'hFFFF_F000_0200, 1'h1, 1'h1, 3'h1);
		rx_case(32'h0000_1040, 6'h3F, 48'hFFFF_F000_027F, 1'h1, 1'h1, 3'h1);
		rx_case(32'h0000_1040, 6'h3F, 48'hFFFF_F000_0280, 1'h1, 1'h1, 3'h4);
		rx_case(32'h0000_8040, 6'h3F, 48'hFFFF_F000_0380, 1'h1, 1'h1, 3'h1);
		rx_case(32'h0000_8040, 6'h3F, 48'hFFFF_F000_037F, 1'h1, 1'h1, 3'h4);
		rx_case(32'h0000_0040, 6'h3F, 48'hFFFF_F000_0200, 1'h1, 1'h1, 3'h4);
		for (int i = 0; i < 4; i++)
		begin
			u_node.send_ack(2'(i));
			bus(1'h0, 8'h08, 32'h0);
			chk({30'h0, rd[17:16]}, 32'(i));
			u_node.resend(2'h0);
			@(negedge clk_i);
			chk({29'h0, tx_resend_o, tx_resend_code_o}, 32'(4 + i));
		end
		u_node.send_ack(2'h1);
		u_node.resend(2'h2);
		@(negedge clk_i);
		chk({29'h0, tx_resend_o, tx_resend_code_o}, 32'h0000_0007);
		bus(1'h1, 8'h08, 32'h0002_0000);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0001_0000);
		c0 = n_txr;
		bus(1'h1, 8'h08, 32'h0000_0400);
		repeat (3) @(posedge clk_i);
		chk(32'(n_txr - c0), 32'h0000_0001);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0000_0000);
		c0 = n_rxr;
		bus(1'h1, 8'h08, 32'h0000_0840);
		repeat (3) @(posedge clk_i);
		chk(32'(n_rxr - c0), 32'h0000_0001);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0000_0040);
		test_done();
	end
endmodule
`default_nettype wire
